//--- rtl/disc_regs_pkg.sv
package disc_regs_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] disc_format_offset   = 8'h10;
  localparam logic [7:0] disc_control_offset  = 8'h12;
  localparam logic [7:0] microcode_data_offset = 8'h32;
  localparam logic [7:0] imem_pointer_offset  = 8'h36;

  // ==========================================================
  // Field positions
  localparam int search_write_enable_bit = 7;
  localparam int sector_sync_search_bit  = 6;
  localparam int data_write_enable_bit   = 5;
  localparam int data_type_lsb           = 3;
  localparam int data_type_msb           = 4;
  localparam int format_msb              = 5;
  localparam int capture_edge_select_bit = 0;
  localparam int low_bit_first_bit       = 3;
  localparam int pointer_msb             = 8;

  // ==========================================================
  // Reset values, read default and pointer step
  localparam logic [5:0]  format_reset  = 6'h00;
  localparam logic [1:0]  data_type_reset = 2'h0;
  localparam logic [8:0]  pointer_reset = 9'h000;
  localparam logic [15:0] read_zero     = 16'h0000;
  localparam logic [8:0]  pointer_step  = 9'h001;

  // ==========================================================
  // Bus carriers
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef struct packed {
    logic        valid;
    logic [8:0]  addr;
    logic [31:0] data;
  } imem_write_t;

endpackage

//--- rtl/edge_capture.sv
`timescale 1ns/1ps
module edge_capture
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Serial input pins and edge select
  input  wire logic bit_clock_pin,
  input  wire logic data_pin,
  input  wire logic falling_select,
  // Captured sample
  output logic      sample_valid,
  output logic      sample_bit
);

  typedef struct packed {
    logic [1:0] clk_sync;
    logic [1:0] dat_sync;
    logic       clk_prev;
    logic       valid;
    logic       bit_value;
  } cap_state_t;

  cap_state_t state;
  cap_state_t next_state;

  always_comb
  begin
    next_state          = state;
    next_state.clk_sync = {state.clk_sync[0], bit_clock_pin};
    next_state.dat_sync = {state.dat_sync[0], data_pin};
    next_state.clk_prev = state.clk_sync[1];
    next_state.valid    = falling_select ?
                          (state.clk_prev & ~state.clk_sync[1]) :
                          (~state.clk_prev & state.clk_sync[1]);
    next_state.bit_value = state.dat_sync[1];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state <= '0;
    else
      state <= next_state;
  end

  assign sample_valid = state.valid;
  assign sample_bit   = state.bit_value;

endmodule

//--- rtl/microcode_load_and_cd_control_regs.sv
// Our own choice: the strobed register port.
`timescale 1ns/1ps
// Functional notes
// - Each pair of written 16-bit words goes into instruction memory at the pointer as one 32-bit word.
// - First word of a pair is upper half, second word lower half.
// - Unpaired write leaves pointer step and memory contents undefined.
// - Search bit 6 changes only when the same write sets bit 7.
// - Search bit high keeps sync search active whatever the data type.
// - Write-only control bits read back indeterminate; here they read zero.
// - Host loads the 9-bit pointer, addressing 32-bit locations, first.
// - Pointer advances by one after every second data write.
// - Edge select: 0 captures on rising bit clock, 1 on falling.
module microcode_load_and_cd_control_regs
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Register port
  input  wire logic [7:0]   reg_addr,
  input  wire logic [15:0]  reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic      [15:0]  reg_rdata,
  // Instruction memory write port
  output logic              imem_wr,
  output logic      [8:0]   imem_addr,
  output logic      [31:0]  imem_data,
  // Disc serial input pins
  input  wire logic         serial_bit_clock,
  input  wire logic         serial_data,
  // Disc interface controls and captured samples
  output logic              sync_search_active,
  output logic      [1:0]   data_type,
  output logic      [5:0]   disc_format,
  output logic              sample_valid,
  output logic              sample_bit
);

  // ==========================================================
  // State
  typedef enum logic
  {
    expect_upper,
    expect_lower
  } pair_phase_t;

  typedef struct packed {
    logic format;
    logic control;
    logic pointer;
    logic microcode;
  } reg_hit_t;

  typedef struct packed {
    logic [5:0]  format;
    logic        search;
    logic [1:0]  dtype;
    logic        search_out;
    logic [8:0]  pointer;
    pair_phase_t phase;
    logic [15:0] upper_word;
    disc_regs_pkg::imem_write_t imem;
    logic [15:0] rdata;
  } regs_state_t;

  regs_state_t             state;
  regs_state_t             next_state;
  disc_regs_pkg::reg_req_t req;
  reg_hit_t                hit;
  logic                    cap_valid;
  logic                    cap_bit;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // ==========================================================
  // Serial capture
  edge_capture capture
  (
    .clk            (clk),
    .rst_n          (rst_n),
    .bit_clock_pin  (serial_bit_clock),
    .data_pin       (serial_data),
    .falling_select (state.format[disc_regs_pkg::capture_edge_select_bit]),
    .sample_valid   (cap_valid),
    .sample_bit     (cap_bit)
  );

  // ==========================================================
  // Address decode
  always_comb
  begin
    hit = '0;
    // One hit at most; unmapped offsets leave all clear
    if (req.addr == disc_regs_pkg::disc_format_offset)
    begin
      hit.format = 1'b1;
    end
    else if (req.addr == disc_regs_pkg::disc_control_offset)
    begin
      hit.control = 1'b1;
    end
    else if (req.addr == disc_regs_pkg::imem_pointer_offset)
    begin
      hit.pointer = 1'b1;
    end
    else if (req.addr == disc_regs_pkg::microcode_data_offset)
    begin
      hit.microcode = 1'b1;
    end
  end

  // ==========================================================
  // Register logic
  always_comb
  begin
    next_state            = state;
    next_state.imem.valid = 1'b0;
    next_state.rdata      = disc_regs_pkg::read_zero;

    // Write path
    if (req.wr && hit.format)
    begin
      next_state.format = req.wdata[disc_regs_pkg::format_msb:0];
    end
    else if (req.wr && hit.control)
    begin
      // Data type follows its own write enable, like the search bit
      if (req.wdata[disc_regs_pkg::data_write_enable_bit])
      begin
        next_state.dtype = req.wdata[disc_regs_pkg::data_type_msb:
                                     disc_regs_pkg::data_type_lsb];
      end
      if (req.wdata[disc_regs_pkg::search_write_enable_bit])
      begin
        next_state.search = req.wdata[disc_regs_pkg::sector_sync_search_bit];
      end
    end
    else if (req.wr && hit.pointer)
    begin
      next_state.pointer = req.wdata[disc_regs_pkg::pointer_msb:0];
      next_state.phase   = expect_upper;
    end
    else if (req.wr && hit.microcode)
    begin
      // An odd word simply waits for a partner; only a pointer write or reset re-syncs the phase
      case (state.phase)
        expect_upper:
        begin
          next_state.upper_word = req.wdata;
          next_state.phase      = expect_lower;
        end
        expect_lower:
        begin
          next_state.imem.valid = 1'b1;
          next_state.imem.addr  = state.pointer;
          next_state.imem.data  = {state.upper_word, req.wdata};
          next_state.pointer    = 9'(state.pointer + disc_regs_pkg::pointer_step);
          next_state.phase      = expect_upper;
        end
      endcase
    end

    // Read path; unmapped offsets keep the zero default
    if (req.rd && hit.format)
    begin
      next_state.rdata = {10'h000, state.format};
    end
    else if (req.rd && hit.control)
    begin
      next_state.rdata = {9'h000, state.search, 1'b0, state.dtype, 3'h0};
    end
    else if (req.rd && hit.pointer)
    begin
      next_state.rdata = {7'h00, state.pointer};
    end
    else if (req.rd && hit.microcode)
    begin
      next_state.rdata = state.upper_word;
    end

    // Search stays on whatever the data type says
    next_state.search_out = state.search | (state.dtype != 2'h0);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      // Pair phase restarts so a fresh load never inherits a half word
      state         <= '0;
      state.format  <= disc_regs_pkg::format_reset;
      state.dtype   <= disc_regs_pkg::data_type_reset;
      state.pointer <= disc_regs_pkg::pointer_reset;
      state.phase   <= expect_upper;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Outputs
  // Register port
  assign reg_rdata          = state.rdata;

  // Instruction memory
  assign imem_wr            = state.imem.valid;
  assign imem_addr          = state.imem.addr;
  assign imem_data          = state.imem.data;

  // Disc interface
  assign sync_search_active = state.search_out;
  assign data_type          = state.dtype;
  assign disc_format        = state.format;
  assign sample_valid       = cap_valid;
  assign sample_bit         = cap_bit;

endmodule

//--- tb/regs_assertions.sv
`timescale 1ns/1ps
module regs_checker
(
  // Bus
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // Outputs
  input wire logic        imem_wr,
  input wire logic [31:0] imem_data,
  input wire logic        sync_search_active,
  input wire logic [1:0]  data_type,
  input wire logic [5:0]  disc_format,
  input wire logic        sample_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic ctl = reg_wr && reg_addr == 8'h12;
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not idle");
  AST_PAIR: assert property (imem_wr |-> $past(reg_wr && reg_addr == 8'h32)
    && imem_data[15:0] == $past(reg_wdata))
    else $error("lower half wrong");
  AST_PULSE: assert property (imem_wr |=> !imem_wr)
    else $error("memory write too long");
  // Search output sits one register behind the control state: two edges
  AST_SE_SET: assert property (ctl && reg_wdata[7:6] == 2'h3 |-> ##2 sync_search_active)
    else $error("search not set");
  AST_SE_KEEP: assert property (ctl && !reg_wdata[7] && !reg_wdata[5]
    |-> ##2 $stable(sync_search_active))
    else $error("search changed");
  AST_TYPE: assert property (ctl && reg_wdata[5] |=> data_type == $past(reg_wdata[4:3]))
    else $error("type not written");
  AST_ACTIVE: assert property (data_type != 2'h0 |-> ##[0:1] sync_search_active)
    else $error("search idle");
  AST_FMT: assert property (reg_wr && reg_addr == 8'h10 |=> disc_format == $past(reg_wdata[5:0]))
    else $error("format not written");
  cover property (imem_wr);
  cover property (ctl && reg_wdata[7]);
  cover property (sample_valid);
endmodule
bind microcode_load_and_cd_control_regs regs_checker chk_u
(
  .clk                (clk),
  .rst_n              (rst_n),
  .reg_addr           (reg_addr),
  .reg_wdata          (reg_wdata),
  .reg_wr             (reg_wr),
  .reg_rd             (reg_rd),
  .reg_rdata          (reg_rdata),
  .imem_wr            (imem_wr),
  .imem_data          (imem_data),
  .sync_search_active (sync_search_active),
  .data_type          (data_type),
  .disc_format        (disc_format),
  .sample_valid       (sample_valid)
);

//--- tb/host_model.sv
`timescale 1ns/1ps
module host_model
(
  // Register port
  input wire logic        clk,
  output logic     [7:0]  reg_addr,
  output logic     [15:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input wire logic [15:0] reg_rdata
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Released data lines flip, so a stale value is never seen as held
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] q);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    // Read data stand in the cycle after the strobe; taken at its closing edge
    @(posedge clk);
    q = reg_rdata;
  endtask
  task automatic load(input logic [8:0] p, input logic [31:0] ins);
    wr(8'h36, {7'h00, p});
    wr(8'h32, ins[31:16]);
    wr(8'h32, ins[15:0]);
  endtask
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0, rst_n = 1'b0, serial_bit_clock = 1'b0, serial_data = 1'b0;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, q;
  logic        reg_wr, reg_rd, imem_wr, sync_search_active, sample_valid, sample_bit, smp;
  logic [8:0]  imem_addr, got_addr;
  logic [31:0] imem_data, got_data;
  logic [1:0]  data_type;
  logic [5:0]  disc_format;
  logic [15:0] cw [5] = '{16'h00C0, 16'h0018, 16'h0038, 16'h0020, 16'h0080};
  logic [15:0] cr [5] = '{16'h0040, 16'h0040, 16'h0058, 16'h0040, 16'h0000};
  int          err_count = 0, cmp_count = 0, cyc = 0;
  host_model host_u
  (
    .clk       (clk),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata)
  );
  microcode_load_and_cd_control_regs dut_u
  (
    .clk                (clk),
    .rst_n              (rst_n),
    .reg_addr           (reg_addr),
    .reg_wdata          (reg_wdata),
    .reg_wr             (reg_wr),
    .reg_rd             (reg_rd),
    .reg_rdata          (reg_rdata),
    .imem_wr            (imem_wr),
    .imem_addr          (imem_addr),
    .imem_data          (imem_data),
    .serial_bit_clock   (serial_bit_clock),
    .serial_data        (serial_data),
    .sync_search_active (sync_search_active),
    .data_type          (data_type),
    .disc_format        (disc_format),
    .sample_valid       (sample_valid),
    .sample_bit         (sample_bit)
  );
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always #10 clk = ~clk;
  // Data settles mid bit so each edge sees a known level
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc[2:0] == 3'h4)
      serial_bit_clock <= ~serial_bit_clock;
    serial_data <= cyc[3];
    if (imem_wr === 1'b1)
    begin
      got_addr <= imem_addr;
      got_data <= imem_data;
    end
    if (sample_valid === 1'b1)
      smp <= sample_bit;
    if (cyc == 2000)
    begin
      err_count++;
      summarize;
    end
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    host_u.load(9'h1FF, 32'hA5C30F96);
    host_u.rd(8'h36, q);
    chk(got_addr, 9'h1FF);
    chk(got_data, 32'hA5C30F96);
    chk(q, 16'h0000);
    host_u.wr(8'h32, 16'h1234);
    host_u.wr(8'h32, 16'h5678);
    host_u.rd(8'h36, q);
    chk(got_addr, 9'h000);
    chk(got_data, 32'h12345678);
    chk(q, 16'h0001);
    $display("pair test end");
    for (int i = 0; i < 5; i++)
    begin
      host_u.wr(8'h12, cw[i]);
      host_u.rd(8'h12, q);
      chk(q, cr[i]);
      chk(sync_search_active, |cr[i]);
      chk(data_type, cr[i][4:3]);
    end
    host_u.rd(8'h3E, q);
    chk(q, 16'h0000);
    $display("control test end");
    host_u.wr(8'h10, 16'h0001);
    repeat (40) @(posedge clk);
    chk(smp, 1'b1);
    chk(disc_format, 6'h01);
    host_u.wr(8'h10, 16'h002E);
    repeat (40) @(posedge clk);
    chk(smp, 1'b0);
    chk(disc_format, 6'h2E);
    host_u.rd(8'h10, q);
    chk(q, 16'h002E);
    $display("format test end");
    summarize;
  end
endmodule
